// ### shared/swo_consts.vh
// Constants for the switch output control block.
`ifndef SWO_CONSTS_VH
`define SWO_CONSTS_VH
`define SWO_FUNC_OFF 3'h0
`define SWO_FUNC_ON 3'h1
`define SWO_FUNC_DIAG 3'h2
`define SWO_FUNC_LIMIT 3'h3
`define SWO_FUNC_DOUT 3'h4
`define SWO_DIAG_ALARM 2'h0
`define SWO_DIAG_ALARM_WARN 2'h1
`define SWO_DIAG_WARN 2'h2
`define SWO_FAIL_ACTUAL 2'h0
`define SWO_FAIL_OPEN 2'h1
`define SWO_FAIL_CLOSED 2'h2
`define SWO_SRC_OFF 4'h0
`define SWO_SRC_AD1 4'h1
`define SWO_SRC_AD2 4'h2
`define SWO_SRC_DO1 4'h3
`define SWO_LIM_OFF 4'h0
`define SWO_CLK_HZ 32'h017d7840
`define SWO_DELAY_STEP_MS 32'h00000064
`define SWO_DELAY_MAX_TENTHS 10'h3e8
`define SWO_TICK_CYCLES ((`SWO_CLK_HZ / 32'h000003e8) * `SWO_DELAY_STEP_MS)
`endif

// ### hw/swo_delay_timer.v
// Qualifies a condition that must persist for a programmed number of 0.1 s ticks.
`timescale 1ns/100ps
`include "swo_consts.vh"
module swo_delay_timer (
  // Clock and reset
  input wire clock,
  input wire resetn,
  input wire clk_en,
  // Control
  input wire tick,
  input wire cond,
  input wire [9:0] delay_tenths,
  // Result
  output reg done
);
  reg [9:0] count_q;
  wire [9:0] limit;

  assign limit = (delay_tenths > `SWO_DELAY_MAX_TENTHS) ? `SWO_DELAY_MAX_TENTHS : delay_tenths;

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= 10'h000;
    end else if (clk_en) begin
      if (!cond) begin
        count_q <= 10'h000; // R21
      end else if (tick && (count_q < limit)) begin
        count_q <= count_q + 10'h001; // R21
      end
    end
  end

  always @* begin
    done = cond && (count_q >= limit); // R21
  end
endmodule

// ### hw/swo_switch_output.v
// Switch output control: source selection, limit hysteresis, delays, failure mode, inversion.
// Notes on behaviour
// R01: Function off holds the output permanently open.
// R02: Function on holds the output permanently closed.
// R03: Diagnostic mode is closed by default, open while a qualifying event is active.
// R04: Diagnostic class selects alarm, alarm or warning, or warning only.
// R05: Limit mode is closed by default, opened by threshold comparison.
// R06: Digital output mode follows the selected discrete block output.
// R07: Source selector offers off, two diagnostic switch signals, eight discrete outputs.
// R08: Switch-on threshold is signed float compared with the selected variable.
// R09: Switch-off threshold is signed float compared with the same variable.
// R10: On above off: close when the value rises above switch-on.
// R11: On above off: open when the value drops below switch-off.
// R12: On below off: close when the value drops below switch-on.
// R13: On below off: open when the value rises above switch-off.
// R14: Switch-on delay of 0.0 to 100.0 s applies in limit mode.
// R15: Switch-off delay of 0.0 to 100.0 s applies in limit mode.
// R16: In limit or digital mode, alarm forces actual, open or closed.
// R17: Present open or closed state is readable.
// R18: Inversion swaps open and closed for all behaviour.
// R19: Operator may use forced open or closed to simulate states.
// R20: Between the thresholds the limit output keeps its previous state.
// R21: A transition needs its condition to persist for the whole delay; the free-running tick lets the delay end up to one tick early.
`timescale 1ns/100ps
`include "swo_consts.vh"
module swo_switch_output (
  // Clock and reset
  input wire clock,
  input wire resetn,
  input wire clk_en,
  // Configuration
  input wire [2:0] func_sel,
  input wire [1:0] diag_sel,
  input wire [3:0] src_sel,
  input wire [3:0] limit_sel,
  input wire [31:0] on_value,
  input wire [31:0] off_value,
  input wire [9:0] on_delay_tenths,
  input wire [9:0] off_delay_tenths,
  input wire [1:0] fail_mode,
  input wire invert,
  // Measured variables, twelve IEEE single values packed, variable 1 in the low word
  input wire [383:0] meas_values,
  // Diagnostic event classes
  input wire diag_alarm,
  input wire diag_warning,
  // Discrete sources: advanced diagnostic 1..2, then discrete_input_block outputs 1..8
  input wire [9:0] discrete_input_block,
  // Switch contact and status
  output reg switch_closed,
  output reg status_closed
);
  // Asynchronous status inputs pass two flip-flops before use.
  reg [1:0] evt_sync1_q;
  reg [1:0] evt_sync2_q;
  reg [9:0] src_sync1_q;
  reg [9:0] src_sync2_q;
  reg [31:0] meas_q;
  reg limit_state_q;
  reg [23:0] tick_cnt_q;
  reg tick_q;
  reg cmp_on_q;
  reg cmp_off_q;
  reg [31:0] sel_val;
  reg dout_val;
  reg base_closed;
  reg want_close;
  reg want_open;
  reg eff_closed;
  reg diag_open;
  wire close_done;
  wire open_done;
  wire alarm_s;
  wire warn_s;
  wire [9:0] dsrc_s;
  wire on_above_off;
  wire limit_active;
  wire fail_active;
  wire tick_wrap;

  assign alarm_s = evt_sync2_q[1];
  assign warn_s = evt_sync2_q[0];
  assign dsrc_s = src_sync2_q;
  assign limit_active = (func_sel == `SWO_FUNC_LIMIT) && (limit_sel != `SWO_LIM_OFF);
  // Failure mode only acts in limit and digital output modes, on the alarm class.
  assign fail_active = ((func_sel == `SWO_FUNC_LIMIT) || (func_sel == `SWO_FUNC_DOUT)) &&
    alarm_s;
  assign tick_wrap = ({8'h00, tick_cnt_q} == (`SWO_TICK_CYCLES - 32'h00000001));

  // Signed float compare: returns 1 when a > b.
  // Positive and negative zero compare equal, and NaN is not treated specially.
  function fgt;
    input [31:0] a;
    input [31:0] b;
    begin
      if (a[30:0] == 31'h0 && b[30:0] == 31'h0) begin
        fgt = 1'b0;
      end else if (a[31] != b[31]) begin
        fgt = b[31];
      end else if (a[31] == 1'b0) begin
        fgt = (a[30:0] > b[30:0]);
      end else begin
        fgt = (a[30:0] < b[30:0]);
      end
    end
  endfunction

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      evt_sync1_q <= 2'h0;
      evt_sync2_q <= 2'h0;
    end else if (clk_en) begin
      evt_sync1_q <= {diag_alarm, diag_warning};
      evt_sync2_q <= evt_sync1_q;
    end
  end

  // Discrete sources get a synchroniser bank of their own.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      src_sync1_q <= 10'h000;
      src_sync2_q <= 10'h000;
    end else if (clk_en) begin
      src_sync1_q <= discrete_input_block;
      src_sync2_q <= src_sync1_q;
    end
  end

  // Selected measured variable; variable code 0 means no limit assigned.
  always @* begin
    case (limit_sel)
      4'h1: sel_val = meas_values[31:0];
      4'h2: sel_val = meas_values[63:32];
      4'h3: sel_val = meas_values[95:64];
      4'h4: sel_val = meas_values[127:96];
      4'h5: sel_val = meas_values[159:128];
      4'h6: sel_val = meas_values[191:160];
      4'h7: sel_val = meas_values[223:192];
      4'h8: sel_val = meas_values[255:224];
      4'h9: sel_val = meas_values[287:256];
      4'ha: sel_val = meas_values[319:288];
      4'hb: sel_val = meas_values[351:320];
      4'hc: sel_val = meas_values[383:352];
      default: sel_val = 32'h00000000;
    endcase
  end

  // Strict compares: a value equal to a threshold counts as inside the band.
  assign on_above_off = fgt(on_value, off_value);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meas_q <= 32'h00000000;
    end else if (clk_en) begin
      // The measured variables share this clock, so they are not synchronised.
      meas_q <= sel_val;
    end
  end

  // Comparisons run one stage after the selection to keep the float compare off the mux path.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmp_on_q <= 1'b0;
      cmp_off_q <= 1'b0;
    end else if (clk_en) begin
      if (on_above_off) begin
        cmp_on_q <= fgt(meas_q, on_value); // R08 R10
        cmp_off_q <= fgt(off_value, meas_q); // R09 R11
      end else begin
        cmp_on_q <= fgt(on_value, meas_q); // R08 R12
        cmp_off_q <= fgt(meas_q, off_value); // R09 R13
      end
    end
  end

  // 0.1 s time base for the delay timers.
  // The tick phase runs free, so a delay may end up to one tick early.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_q <= 24'h000000;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (tick_wrap) begin
        tick_cnt_q <= 24'h000000;
        tick_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 24'h000001;
        tick_q <= 1'b0;
      end
    end
  end

  always @* begin
    // A timer only runs while its transition would change the state, so a lapse restarts it.
    want_close = limit_active && cmp_on_q && !limit_state_q;
    want_open = limit_active && cmp_off_q && limit_state_q;
  end

  swo_delay_timer u_on_timer (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .tick(tick_q),
    .cond(want_close),
    .delay_tenths(on_delay_tenths),
    .done(close_done)
  );

  swo_delay_timer u_off_timer (
    .clock(clock),
    .resetn(resetn),
    .clk_en(clk_en),
    .tick(tick_q),
    .cond(want_open),
    .delay_tenths(off_delay_tenths),
    .done(open_done)
  );

  // Limit hysteresis state; closed by default.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      limit_state_q <= 1'b1;
    end else if (clk_en) begin
      if (!limit_active) begin
        limit_state_q <= 1'b1; // R05
      end else if (close_done) begin
        limit_state_q <= 1'b1; // R10 R12 R14
      end else if (open_done) begin
        limit_state_q <= 1'b0; // R11 R13 R15
      end else begin
        limit_state_q <= limit_state_q; // R20
      end
    end
  end

  // Unused source codes leave the output open.
  always @* begin
    case (src_sel)
      `SWO_SRC_OFF: dout_val = 1'b0; // R07
      `SWO_SRC_AD1: dout_val = dsrc_s[0]; // R07
      `SWO_SRC_AD2: dout_val = dsrc_s[1]; // R07
      `SWO_SRC_DO1: dout_val = dsrc_s[2]; // R07
      4'h4: dout_val = dsrc_s[3]; // R07
      4'h5: dout_val = dsrc_s[4]; // R07
      4'h6: dout_val = dsrc_s[5]; // R07
      4'h7: dout_val = dsrc_s[6]; // R07
      4'h8: dout_val = dsrc_s[7]; // R07
      4'h9: dout_val = dsrc_s[8]; // R07
      4'ha: dout_val = dsrc_s[9]; // R07
      default: dout_val = 1'b0;
    endcase
  end

  // Code 3 of the class selector behaves as alarm only.
  always @* begin
    case (diag_sel)
      `SWO_DIAG_ALARM: diag_open = alarm_s; // R04
      `SWO_DIAG_ALARM_WARN: diag_open = alarm_s | warn_s; // R04
      `SWO_DIAG_WARN: diag_open = warn_s; // R04
      default: diag_open = alarm_s;
    endcase
  end

  // Unknown function codes leave the contact open.
  always @* begin
    case (func_sel)
      `SWO_FUNC_OFF: base_closed = 1'b0; // R01
      `SWO_FUNC_ON: base_closed = 1'b1; // R02
      `SWO_FUNC_DIAG: base_closed = !diag_open; // R03
      `SWO_FUNC_LIMIT: base_closed = limit_state_q; // R05
      `SWO_FUNC_DOUT: base_closed = dout_val; // R06
      default: base_closed = 1'b0;
    endcase
  end

  always @* begin
    eff_closed = base_closed;
    if (fail_active) begin
      case (fail_mode)
        `SWO_FAIL_OPEN: eff_closed = 1'b0; // R16
        `SWO_FAIL_CLOSED: eff_closed = 1'b1; // R16
        default: eff_closed = base_closed; // R16
      endcase
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      switch_closed <= 1'b0;
    end else if (clk_en) begin
      // Inversion follows the failure override, so forced states are swapped too.
      switch_closed <= eff_closed ^ invert; // R18
    end
  end

  // Status has its own flip-flop so that reading it never loads the contact driver.
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_closed <= 1'b0;
    end else if (clk_en) begin
      status_closed <= eff_closed ^ invert; // R17
    end
  end
endmodule

// ### dv/swo_contact_sense.sv
// Far-side contact sensing circuit with a pull-up on the open contact.
`timescale 1ns/100ps
module swo_contact_sense (
  // Contact
  input wire switch_closed,
  // Sensed level, pulled high while the contact is open
  output wire sense_n
);
  assign sense_n = !switch_closed;
endmodule

// ### dv/swo_switch_output_asserts.sv
// Port checks for the switch output block.
`timescale 1ns/100ps
`include "swo_consts.vh"
module swo_switch_output_asserts (
  // Inputs
  input wire clock,
  input wire resetn,
  input wire clk_en,
  input wire [2:0] func_sel,
  input wire [1:0] diag_sel,
  input wire [3:0] src_sel,
  input wire [1:0] fail_mode,
  input wire invert,
  input wire diag_alarm,
  input wire diag_warning,
  input wire [9:0] discrete_input_block,
  // Outputs
  input wire switch_closed,
  input wire status_closed
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  wire dg = clk_en && !invert && func_sel == `SWO_FUNC_DIAG;
  wire dt = clk_en && !invert && func_sel == `SWO_FUNC_DOUT && src_sel == `SWO_SRC_DO1;
  a_off_open: assert property (clk_en && func_sel == `SWO_FUNC_OFF |=>
    switch_closed == $past(invert)) else $error("off state wrong");
  a_on_closed: assert property (clk_en && func_sel == `SWO_FUNC_ON |=>
    switch_closed != $past(invert)) else $error("on state wrong");
  a_status_same: assert property (status_closed == switch_closed)
    else $error("status differs");
  a_diag_idle: assert property ((dg && !diag_alarm && !diag_warning)[*4] |=>
    switch_closed) else $error("diag idle not closed");
  a_diag_alarm: assert property ((dg && diag_sel == `SWO_DIAG_ALARM && diag_alarm)[*4]
    |=> !switch_closed) else $error("alarm not open");
  a_warn_only: assert property ((dg && diag_sel == `SWO_DIAG_WARN && !diag_warning)[*4]
    |=> switch_closed) else $error("warn only not closed");
  a_dout_follow: assert property ((dt && fail_mode == `SWO_FAIL_ACTUAL && !diag_alarm
    && $stable(discrete_input_block))[*4] |=> switch_closed == $past(discrete_input_block[2], 3))
    else $error("source not followed");
  a_fail_open: assert property ((dt && fail_mode == `SWO_FAIL_OPEN && diag_alarm)[*4]
    |=> !switch_closed) else $error("fail open wrong");
  a_fail_closed: assert property ((dt && fail_mode == `SWO_FAIL_CLOSED && diag_alarm)[*4]
    |=> switch_closed) else $error("fail closed wrong");
  c_limit: cover property (func_sel == `SWO_FUNC_LIMIT && switch_closed);
  c_diag: cover property (dg && !switch_closed);
  c_fail: cover property (dt && diag_alarm && switch_closed);
endmodule
bind swo_switch_output swo_switch_output_asserts u_swo_switch_output_asserts (.clock, .resetn,
  .clk_en, .func_sel, .diag_sel, .src_sel, .fail_mode, .invert, .diag_alarm, .diag_warning,
  .discrete_input_block, .switch_closed, .status_closed);

// ### dv/swo_switch_output_tb_top.sv
// Self-checking testbench for the switch output block.
`timescale 1ns/100ps
`include "swo_consts.vh"
module swo_switch_output_tb_top;
  reg clock = 1'h0;
  reg resetn = 1'h0;
  reg clk_en = 1'h1;
  reg invert = 1'h0;
  reg diag_alarm = 1'h0;
  reg diag_warning = 1'h0;
  reg [2:0] func_sel = 3'h0;
  reg [1:0] diag_sel = 2'h0;
  reg [1:0] fail_mode = 2'h0;
  reg [3:0] src_sel = 4'h0;
  reg [3:0] limit_sel = 4'h1;
  reg [31:0] on_value = 32'h0;
  reg [31:0] off_value = 32'h0;
  reg [9:0] delay = 10'h0;
  reg [9:0] discrete_input_block = 10'h0;
  reg [383:0] meas_values = 384'h0;
  wire switch_closed;
  wire status_closed;
  wire sense_n;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  always #20 clock = ~clock;
  swo_switch_output u_swo_switch_output (.clock, .resetn, .clk_en, .func_sel, .diag_sel,
    .src_sel, .limit_sel, .on_value, .off_value, .on_delay_tenths(delay),
    .off_delay_tenths(delay), .fail_mode, .invert, .meas_values, .diag_alarm, .diag_warning,
    .discrete_input_block, .switch_closed, .status_closed);
  swo_contact_sense u_swo_contact_sense (.switch_closed, .sense_n);
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Waits past the longest input-to-output path, then compares contact, status and sensed line.
  task chk(input logic e);
    repeat (6) @(negedge clock);
    num_checks++;
    if (switch_closed !== (e ^ invert) || status_closed !== (e ^ invert) || sense_n !== !(e ^ invert)) begin
      err_total++;
      $display("ERROR %0t contact %b expected %b", $time, switch_closed, e ^ invert);
    end
  endtask
  task t_fixed;
    for (int i = 0; i < 2; i++) begin
      invert = i[0];
      func_sel = `SWO_FUNC_OFF;
      chk(1'h0);
      func_sel = `SWO_FUNC_ON;
      chk(1'h1);
    end
    invert = 1'h0;
    func_sel = `SWO_FUNC_ON;
    chk(1'h1);
    clk_en = 1'h0;
    func_sel = `SWO_FUNC_OFF;
    chk(1'h1);
    clk_en = 1'h1;
    chk(1'h0);
    $display("t_fixed done");
  endtask
  task t_diag;
    func_sel = `SWO_FUNC_DIAG;
    for (int s = 0; s < 3; s++) begin
      for (int e = 0; e < 4; e++) begin
        diag_sel = s[1:0];
        {diag_warning, diag_alarm} = e[1:0];
        chk(!((s != 2 && e[0]) || (s != 0 && e[1])));
      end
    end
    {diag_warning, diag_alarm} = 2'h0;
    $display("t_diag done");
  endtask
  task t_dout;
    func_sel = `SWO_FUNC_DOUT;
    for (int k = 0; k < 2; k++) begin
      discrete_input_block = k ? 10'h15a : 10'h2a5;
      for (int s = 0; s < 11; s++) begin
        src_sel = s[3:0];
        chk(s > 0 && discrete_input_block[s - 1]);
      end
    end
    src_sel = `SWO_SRC_DO1;
    discrete_input_block = 10'h0;
    diag_alarm = 1'h1;
    for (int f = 0; f < 3; f++) begin
      fail_mode = f[1:0];
      chk(f == 2);
    end
    discrete_input_block = 10'h3ff;
    fail_mode = `SWO_FAIL_OPEN;
    chk(1'h0);
    fail_mode = `SWO_FAIL_ACTUAL;
    chk(1'h1);
    diag_alarm = 1'h0;
    fail_mode = `SWO_FAIL_ACTUAL;
    $display("t_dout done");
  endtask
  task lim(input [31:0] v, input logic e);
    meas_values[31:0] = v;
    chk(e);
  endtask
  // Thresholds 2.0 over 1.0, then -1.0 under 1.0; values between them must hold the state.
  task t_limit;
    func_sel = `SWO_FUNC_LIMIT;
    on_value = 32'h40000000;
    off_value = 32'h3f800000;
    lim(32'h40400000, 1'h1);
    lim(32'h3fc00000, 1'h1);
    lim(32'h3f000000, 1'h0);
    lim(32'h3fc00000, 1'h0);
    on_value = 32'hbf800000;
    lim(32'hc0000000, 1'h1);
    lim(32'h00000000, 1'h1);
    lim(32'h40000000, 1'h0);
    lim(32'h00000000, 1'h0);
    limit_sel = `SWO_LIM_OFF;
    chk(1'h1);
    meas_values[383:352] = 32'h40000000;
    limit_sel = 4'hc;
    chk(1'h0);
    // No delay tick falls in this run, so a nonzero delay must hold the state.
    delay = 10'h001;
    meas_values[383:352] = 32'hc0000000;
    chk(1'h0);
    delay = 10'h000;
    chk(1'h1);
    delay = 10'h001;
    meas_values[383:352] = 32'h40000000;
    chk(1'h1);
    delay = 10'h000;
    chk(1'h0);
    diag_alarm = 1'h1;
    fail_mode = `SWO_FAIL_CLOSED;
    chk(1'h1);
    diag_alarm = 1'h0;
    fail_mode = `SWO_FAIL_ACTUAL;
    chk(1'h0);
    $display("t_limit done");
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (2) @(negedge clock);
    resetn = 1'h1;
    t_fixed();
    t_diag();
    t_dout();
    t_limit();
    end_of_test();
  end
endmodule
